// *** fifo_watermark.sv ***
// fifo watermark comparators for the nearly-full and nearly-empty alerts
// assumes fill count and threshold come from the same clock domain
`timescale 1ns/1ns
`include "summary_status_regs.svh"

module fifo_watermark
#(
    parameter int COUNT_W = 7,
    parameter int THRESH_W = 6
)
(
    input  wire logic [COUNT_W-1:0]  fifo_fill_count,
    input  wire logic [THRESH_W-1:0] fifo_threshold,
    output logic                     nearly_full,
    output logic                     nearly_empty
);

    logic [COUNT_W-1:0] free_space;
    logic [COUNT_W-1:0] threshold_wide;

    ////////////////////////////////////////////////////////////////////////
    // free space is capacity minus fill count
    always_comb
    begin
        threshold_wide = COUNT_W'(fifo_threshold);
        free_space     = COUNT_W'(`FIFO_CAPACITY - fifo_fill_count);
        nearly_full    = (free_space <= threshold_wide);        // [R10]
        nearly_empty   = (fifo_fill_count <= threshold_wide);   // [R11]
    end

endmodule

// *** level_sync.sv ***
// three-stage level synchroniser for an asynchronous pin
// assumes core_clk is free running; output changes when stages 1 and 2 agree
`timescale 1ns/1ns

module level_sync
(
    input  wire logic core_clk,
    input  wire logic rstn,
    input  wire logic async_in,
    output logic      sync_out
);

    logic [2:0] stage_reg;

    ////////////////////////////////////////////////////////////////////////
    // shift chain; stage 0 feeds only stage 1
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            stage_reg <= 3'h0;
        else
            stage_reg <= {stage_reg[1:0], async_in};
    end

    ////////////////////////////////////////////////////////////////////////
    // accept a new level only once two later stages agree
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            sync_out <= 1'b0;
        else if (stage_reg[1] == stage_reg[2])
            sync_out <= stage_reg[2];
    end

endmodule

// *** summary_status.sv ***
// summary status register bank with avalon-mm slave and event interrupt
// assumes source units share core_clk except the two rf detector pins
`timescale 1ns/1ns
`include "summary_status_regs.svh"

// Functional notes
// R1: field_frequency_valid reads 1 while the rx carrier is strictly between 12 and 15 MHz.
// R2: field_frequency_valid has no guaranteed value for carriers of 9-12 MHz or 15-19 MHz.
// R3: checksum_zero_result reads 1 for a zero checksum, 0 while computing, 1 after a good finish.
// R4: checksum_zero_result is undefined during transmit and receive; the error flag is used then.
// R5: checksum_done goes to 1 when a checksum completes and is meaningful for compute_checksum_cmd.
// R6: the attention flag is 1 when any interrupt source is active with its enable set in either register.
// R7: countdown_active is 1 while the timer will decrement on its next tick.
// R8: in gated mode countdown_active follows the enable bits only, never the gate signal.
// R9: external_field_present is a live, unlatched level of the field detector.
// R10: fifo_nearly_full is 1 exactly when 64 minus the fill count is at most the threshold.
// R11: fifo_nearly_empty is 1 exactly when the fill count is at most the threshold.
// R12: summary_status is read-only; after reset bits 6 and 1 read 1 and bits 5, 4 and 2 read 0.
// R13: writes to summary_status are ignored and each flag is resampled every clock.
module summary_status
    import summary_status_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int CHECKSUM_W = 16,
    parameter int COMM_IRQ_W = 7,
    parameter int MISC_IRQ_W = 5,
    parameter int COUNT_W = 7,
    parameter int THRESH_W = 6
)
(
    input  wire logic                  core_clk,
    input  wire logic                  rstn,
    input  wire logic [ADDR_W-1:0]     avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [31:0]           avs_writedata,
    input  wire logic [3:0]            avs_byteenable,
    output logic [31:0]                avs_readdata,
    output logic                       avs_waitrequest,
    input  wire logic                  rx_freq_in_band,
    input  wire logic                  field_detect,
    input  wire logic [CHECKSUM_W-1:0] checksum_result,
    input  wire logic                  checksum_busy,
    input  wire logic                  checksum_finish,
    input  wire logic                  compute_checksum_cmd,
    input  wire logic                  link_active,
    input  wire logic [COMM_IRQ_W-1:0] comm_irq_source,
    input  wire logic [COMM_IRQ_W-1:0] comm_irq_enable_register,
    input  wire logic [MISC_IRQ_W-1:0] misc_irq_source,
    input  wire logic [MISC_IRQ_W-1:0] misc_irq_enable_register,
    input  wire logic                  timer_running,
    input  wire logic                  timer_gated_mode,
    input  wire logic                  timer_enable_bits,
    input  wire logic [COUNT_W-1:0]    fifo_fill_count,
    input  wire logic [THRESH_W-1:0]   fifo_threshold,
    output logic                       irq
);

    ////////////////////////////////////////////////////////////////////////
    // declarations

    bus_state_t   bus_state_reg;
    bus_state_t   bus_state_next;
    status_byte_t summary_status_reg;
    status_byte_t summary_status_next;
    status_byte_t prev_status_reg;
    status_byte_t event_status_reg;
    status_byte_t event_status_next;
    status_byte_t event_mask_reg;
    status_byte_t event_raise;
    status_byte_t event_clear;
    logic [31:0]  readdata_next;
    logic [5:0]   word_index;
    logic         access;
    logic         write_take;
    logic         field_frequency_valid;
    logic         external_field_present;
    logic         checksum_zero_result;
    logic         checksum_done_reg;
    logic         attention_pending;
    logic         countdown_active;
    logic         fifo_nearly_full;
    logic         fifo_nearly_empty;
    logic         field_edge_reg;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // word index of a byte address
    function automatic logic [5:0] word_of(input logic [ADDR_W-1:0] addr);
        word_of = addr[7:2];
    endfunction

    // write-one-to-clear mask from the low byte lane
    function automatic status_byte_t lane0_bits
    (
        input logic [31:0] data,
        input logic [3:0]  lanes
    );
        lane0_bits = lanes[0] ? data[7:0] : 8'h00;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers for the rf detector outputs

    level_sync u_freq_sync
    (
        .core_clk (core_clk),
        .rstn     (rstn),
        .async_in (rx_freq_in_band),
        .sync_out (field_frequency_valid)
    );

    level_sync u_field_sync
    (
        .core_clk (core_clk),
        .rstn     (rstn),
        .async_in (field_detect),
        .sync_out (external_field_present)
    );

    ////////////////////////////////////////////////////////////////////////
    // fifo watermark alerts

    fifo_watermark
    #(
        .COUNT_W  (COUNT_W),
        .THRESH_W (THRESH_W)
    )
    u_watermark
    (
        .fifo_fill_count (fifo_fill_count),
        .fifo_threshold  (fifo_threshold),
        .nearly_full     (fifo_nearly_full),
        .nearly_empty    (fifo_nearly_empty)
    );

    ////////////////////////////////////////////////////////////////////////
    // checksum flags

    // zero result only when idle; value during link traffic is not meaningful
    always_comb
    begin
        checksum_zero_result = ~checksum_busy & (checksum_result == '0); // [R3] [R4]
    end

    // done flag: set on finish, cleared when a new computation starts
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            checksum_done_reg <= 1'b0;
        else if (checksum_finish)
            checksum_done_reg <= 1'b1;                    // [R5]
        else if (compute_checksum_cmd | checksum_busy)
            checksum_done_reg <= 1'b0;                    // [R5]
    end

    ////////////////////////////////////////////////////////////////////////
    // attention and countdown flags

    always_comb
    begin
        attention_pending = (|(comm_irq_source & comm_irq_enable_register))
                          | (|(misc_irq_source & misc_irq_enable_register)); // [R6]
        if (timer_gated_mode)
            countdown_active = timer_enable_bits;         // [R8]
        else
            countdown_active = timer_running;             // [R7]
    end

    ////////////////////////////////////////////////////////////////////////
    // summary status assembly, resampled every clock

    always_comb
    begin
        summary_status_next = 8'h00;
        summary_status_next[`BIT_FIELD_FREQ_VALID]  = field_frequency_valid;  // [R1] [R2]
        summary_status_next[`BIT_CHECKSUM_ZERO]     = checksum_zero_result;
        summary_status_next[`BIT_CHECKSUM_DONE]     = checksum_done_reg;
        summary_status_next[`BIT_ATTENTION]         = attention_pending;
        summary_status_next[`BIT_COUNTDOWN_ACTIVE]  = countdown_active;
        summary_status_next[`BIT_FIELD_PRESENT]     = external_field_present; // [R9]
        summary_status_next[`BIT_FIFO_NEARLY_FULL]  = fifo_nearly_full;       // [R10]
        summary_status_next[`BIT_FIFO_NEARLY_EMPTY] = fifo_nearly_empty;      // [R11]
    end

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            summary_status_reg <= `SUMMARY_STATUS_RESET;  // [R12]
        else
            summary_status_reg <= summary_status_next;    // [R13]
    end

    ////////////////////////////////////////////////////////////////////////
    // event detection: rising edge of each summary flag

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            prev_status_reg <= `SUMMARY_STATUS_RESET;
        else
            prev_status_reg <= summary_status_reg;
    end

    // field loss is reported too, in the field-present slot edge tracker
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            field_edge_reg <= 1'b0;
        else
            field_edge_reg <= prev_status_reg[`BIT_FIELD_PRESENT]
                            & ~summary_status_reg[`BIT_FIELD_PRESENT];
    end

    always_comb
    begin
        event_raise = summary_status_reg & ~prev_status_reg;
        event_raise[`BIT_FIELD_PRESENT] = event_raise[`BIT_FIELD_PRESENT] | field_edge_reg;
    end

    ////////////////////////////////////////////////////////////////////////
    // avalon-mm slave: one wait cycle, then answer

    always_comb
    begin
        access     = avs_read | avs_write;
        word_index = word_of(avs_address);
        write_take = avs_write & (bus_state_reg == BUS_ANSWER);
    end

    always_comb
    begin
        case (bus_state_reg)
            BUS_IDLE:
            begin
                if (access)
                    bus_state_next = BUS_ANSWER;
                else
                    bus_state_next = BUS_IDLE;
            end
            BUS_ANSWER:
                bus_state_next = BUS_RELEASE;
            BUS_RELEASE:
                bus_state_next = BUS_IDLE;
            default:
                bus_state_next = BUS_IDLE;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            bus_state_reg <= BUS_IDLE;
        else
            bus_state_reg <= bus_state_next;
    end

    // waitrequest drops only in the answer cycle
    always_comb
    begin
        avs_waitrequest = access & (bus_state_reg != BUS_ANSWER);
    end

    ////////////////////////////////////////////////////////////////////////
    // read data, captured in the first request cycle

    always_comb
    begin
        readdata_next = 32'h0000_0000;
        case (word_index)
            `SUMMARY_STATUS_IDX:
                readdata_next = {24'h00_0000, summary_status_reg};
            `EVENT_STATUS_IDX:
                readdata_next = {24'h00_0000, event_status_reg};
            `EVENT_MASK_IDX:
                readdata_next = {24'h00_0000, event_mask_reg};
            `SOURCE_LEVEL_IDX:
                readdata_next = {24'h00_0000, summary_status_next};
            default:
                readdata_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            avs_readdata <= 32'h0000_0000;
        else if (avs_read & (bus_state_reg == BUS_IDLE))
            avs_readdata <= readdata_next;
    end

    ////////////////////////////////////////////////////////////////////////
    // writable registers, written at the answer edge; the summary word has no write path

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            event_mask_reg <= `EVENT_MASK_RESET;
        else if (write_take & (word_index == `EVENT_MASK_IDX) & avs_byteenable[0])
            event_mask_reg <= avs_writedata[7:0];
    end

    // write one to clear; a new event in the same cycle wins
    always_comb
    begin
        event_clear = 8'h00;
        if (write_take & (word_index == `EVENT_STATUS_IDX))
            event_clear = lane0_bits(avs_writedata, avs_byteenable);
        event_status_next = (event_status_reg & ~event_clear) | event_raise;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            event_status_reg <= `EVENT_STATUS_RESET;
        else
            event_status_reg <= event_status_next;
    end

    ////////////////////////////////////////////////////////////////////////
    // level interrupt

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            irq <= 1'b0;
        else
            irq <= |(event_status_next & event_mask_reg);
    end

endmodule

// *** summary_status_checker.sv ***
// concurrent checks on the summary status block ports
// assumes it is bound to summary_status and sees only its ports
`timescale 1ns/1ns

module summary_status_checker
#(
    parameter int ADDR_W     = 8,
    parameter int CHECKSUM_W = 16,
    parameter int COMM_IRQ_W = 7,
    parameter int MISC_IRQ_W = 5,
    parameter int COUNT_W    = 7,
    parameter int THRESH_W   = 6
)
(
    input wire logic                  core_clk,
    input wire logic                  rstn,
    input wire logic [ADDR_W-1:0]     avs_address,
    input wire logic                  avs_read,
    input wire logic                  avs_write,
    input wire logic [31:0]           avs_readdata,
    input wire logic                  avs_waitrequest,
    input wire logic                  rx_freq_in_band,
    input wire logic                  field_detect,
    input wire logic [CHECKSUM_W-1:0] checksum_result,
    input wire logic                  checksum_busy,
    input wire logic                  checksum_finish,
    input wire logic                  compute_checksum_cmd,
    input wire logic                  link_active,
    input wire logic [COMM_IRQ_W-1:0] comm_irq_source,
    input wire logic [COMM_IRQ_W-1:0] comm_irq_enable_register,
    input wire logic [MISC_IRQ_W-1:0] misc_irq_source,
    input wire logic [MISC_IRQ_W-1:0] misc_irq_enable_register,
    input wire logic                  timer_running,
    input wire logic                  timer_gated_mode,
    input wire logic                  timer_enable_bits,
    input wire logic [COUNT_W-1:0]    fifo_fill_count,
    input wire logic [THRESH_W-1:0]   fifo_threshold
);
    ////////////////////////////////////////////////////////////////
    // helper: cycles since sources last changed, checksum done state
    logic [CHECKSUM_W+2*COMM_IRQ_W+2*MISC_IRQ_W+COUNT_W+THRESH_W+5:0] src, src_prev;
    logic [1:0] pin_prev;
    logic [2:0] calm;
    logic [3:0] pin_calm;
    logic       done_exp;

    assign src = {checksum_result, checksum_busy, checksum_finish, compute_checksum_cmd,
                  comm_irq_source, comm_irq_enable_register, misc_irq_source, misc_irq_enable_register,
                  timer_running, timer_gated_mode, timer_enable_bits, fifo_fill_count, fifo_threshold};

    always_ff @(posedge core_clk)
    begin
        src_prev <= src;
        pin_prev <= {rx_freq_in_band, field_detect};
    end

    always_ff @(posedge core_clk)
    begin
        if (!rstn || src != src_prev)
            calm <= 3'h0;
        else if (calm != 3'h7)
            calm <= calm + 3'h1;
        if (!rstn || pin_prev != {rx_freq_in_band, field_detect})
            pin_calm <= 4'h0;
        else if (pin_calm != 4'hF)
            pin_calm <= pin_calm + 4'h1;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            done_exp <= 1'b0;
        else if (checksum_finish)
            done_exp <= 1'b1;
        else if (compute_checksum_cmd || checksum_busy)
            done_exp <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////
    // read answers of the status word with settled sources; upper-bit and wait-bound checks cover any request
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    sequence status_answer;
        avs_read && !avs_waitrequest && avs_address == 8'h1C;
    endsequence
    sequence core_answer;
        status_answer ##0 calm > 3'h3;
    endsequence
    sequence pin_answer;
        status_answer ##0 pin_calm > 4'h7;
    endsequence

    a_full_alert:
        assert property (core_answer |-> avs_readdata[1] == (7'h40 - fifo_fill_count <= fifo_threshold))
        else $error("fifo nearly full bit wrong");
    a_empty_alert:
        assert property (core_answer |-> avs_readdata[0] == (fifo_fill_count <= fifo_threshold))
        else $error("fifo nearly empty bit wrong");
    a_attention_flag:
        assert property (core_answer |-> avs_readdata[4] == (|(comm_irq_source & comm_irq_enable_register)
            || |(misc_irq_source & misc_irq_enable_register))) else $error("attention bit wrong");
    a_countdown_flag:
        assert property (core_answer |-> avs_readdata[3] == (timer_gated_mode ? timer_enable_bits : timer_running))
        else $error("countdown bit wrong");
    a_zero_result:
        assert property (core_answer ##0 !link_active |-> avs_readdata[6] == (checksum_result == '0 && !checksum_busy))
        else $error("checksum zero bit wrong");
    a_done_flag:
        assert property (core_answer |-> avs_readdata[5] == done_exp)
        else $error("checksum done bit wrong");
    a_field_level:
        assert property (pin_answer |-> avs_readdata[2] == field_detect)
        else $error("field present bit wrong");
    a_freq_flag:
        assert property (pin_answer |-> avs_readdata[7] == rx_freq_in_band)
        else $error("frequency valid bit wrong");
    a_upper_zero:
        assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    a_wait_bounded:
        assert property ((avs_read || avs_write) && avs_waitrequest |-> ##[1:3] !avs_waitrequest)
        else $error("bus request not answered");
endmodule

// *** summary_status_pkg.sv ***
// types shared by the summary status block
// assumes the register header is included where offsets are needed
package summary_status_pkg;

    typedef enum logic [1:0]
    {
        BUS_IDLE,
        BUS_ANSWER,
        BUS_RELEASE
    } bus_state_t;

    typedef logic [7:0] status_byte_t;

endpackage

// *** summary_status_regs.svh ***
// summary status register map: indices, bit positions, reset values
// assumes registers are 32-bit words at byte address = 4 * index
`ifndef SUMMARY_STATUS_REGS_SVH
`define SUMMARY_STATUS_REGS_SVH

// register indices
`define SUMMARY_STATUS_IDX    6'h07
`define EVENT_STATUS_IDX      6'h10
`define EVENT_MASK_IDX        6'h11
`define SOURCE_LEVEL_IDX      6'h12

// summary_status bit positions
`define BIT_FIELD_FREQ_VALID  3'd7
`define BIT_CHECKSUM_ZERO     3'd6
`define BIT_CHECKSUM_DONE     3'd5
`define BIT_ATTENTION         3'd4
`define BIT_COUNTDOWN_ACTIVE  3'd3
`define BIT_FIELD_PRESENT     3'd2
`define BIT_FIFO_NEARLY_FULL  3'd1
`define BIT_FIFO_NEARLY_EMPTY 3'd0

// reset values
`define SUMMARY_STATUS_RESET  8'h42
`define EVENT_STATUS_RESET    8'h00
`define EVENT_MASK_RESET      8'h00

// fifo capacity in bytes
`define FIFO_CAPACITY         7'h40

// synchroniser depth
`define SYNC_STAGES           3

`endif

// *** testbench.sv ***
// self-checking bench for the summary status block
// assumes default widths of summary_status and a 10 MHz core clock
`timescale 1ns/1ns

module testbench;
    logic        core_clk, rstn, avs_read, avs_write, avs_waitrequest, irq, done_model;
    logic [7:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [3:0]  avs_byteenable;
    logic        rx_freq_in_band, field_detect, checksum_busy, checksum_finish, compute_checksum_cmd, link_active;
    logic [15:0] checksum_result;
    logic [6:0]  comm_irq_source, comm_irq_enable_register, fifo_fill_count;
    logic [4:0]  misc_irq_source, misc_irq_enable_register;
    logic        timer_running, timer_gated_mode, timer_enable_bits;
    logic [5:0]  fifo_threshold;
    int          mismatches, checks_done;

    summary_status summary_status_inst (.core_clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .rx_freq_in_band, .field_detect, .checksum_result,
        .checksum_busy, .checksum_finish, .compute_checksum_cmd, .link_active, .comm_irq_source,
        .comm_irq_enable_register, .misc_irq_source, .misc_irq_enable_register, .timer_running,
        .timer_gated_mode, .timer_enable_bits, .fifo_fill_count, .fifo_threshold, .irq);

    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////
    // shared tasks
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        avs_read <= !wr;
        avs_write <= wr;
        avs_address <= a;
        avs_writedata <= d;
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 20);
        if (avs_waitrequest !== 1'b0)
        begin
            mismatches++;
            results();
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    function automatic logic [7:0] model();
        model[7] = rx_freq_in_band;
        model[6] = checksum_result == 16'h0 && !checksum_busy;
        model[5] = done_model;
        model[4] = |(comm_irq_source & comm_irq_enable_register) || |(misc_irq_source & misc_irq_enable_register);
        model[3] = timer_gated_mode ? timer_enable_bits : timer_running;
        model[2] = field_detect;
        model[1] = 7'h40 - fifo_fill_count <= {1'b0, fifo_threshold};
        model[0] = fifo_fill_count <= {1'b0, fifo_threshold};
    endfunction

    task automatic st(input logic [7:0] mask);
        idle(10);
        bus(1'b0, 8'h1C, 32'h0);
        check(rd & {24'hFFFFFF, mask}, {24'h0, model() & mask});
    endtask

    ////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_fifo();
        logic [12:0] tbl [6] = '{{7'h3C, 6'h04}, {7'h3B, 6'h04}, {7'h04, 6'h04},
                                 {7'h05, 6'h04}, {7'h40, 6'h00}, {7'h20, 6'h20}};
        foreach (tbl[i])
        begin
            fifo_fill_count <= tbl[i][12:6];
            fifo_threshold <= tbl[i][5:0];
            st(8'h03);
        end
        $display("fifo watermark test done");
    endtask

    task automatic t_attention();
        logic [6:0] c;
        logic [4:0] m;
        for (int i = 0; i < 12; i++)
        begin
            c = i < 7 ? 7'h01 << i : 7'h00;
            m = i < 7 ? 5'h00 : 5'h01 << (i - 7);
            comm_irq_source <= c;
            misc_irq_source <= m;
            comm_irq_enable_register <= i % 2 ? ~c : c;
            misc_irq_enable_register <= i % 2 ? ~m : m;
            st(8'h10);
        end
        $display("attention test done");
    endtask

    task automatic t_timer();
        for (int i = 0; i < 8; i++)
        begin
            {timer_gated_mode, timer_enable_bits, timer_running} <= i[2:0];
            st(8'h08);
        end
        $display("countdown test done");
    endtask

    task automatic t_checksum();
        checksum_result <= 16'h0;
        st(8'h60);
        checksum_busy <= 1'b1;
        compute_checksum_cmd <= 1'b1;
        done_model = 1'b0;
        @(posedge core_clk);
        compute_checksum_cmd <= 1'b0;
        st(8'h60);
        checksum_result <= 16'h1234;
        checksum_busy <= 1'b0;
        st(8'h40);
        checksum_result <= 16'h0;
        checksum_finish <= 1'b1;
        done_model = 1'b1;
        @(posedge core_clk);
        checksum_finish <= 1'b0;
        st(8'h60);
        $display("checksum test done");
    endtask

    task automatic t_pins();
        for (int i = 0; i < 4; i++)
        begin
            {rx_freq_in_band, field_detect} <= ~i[1:0];
            st(8'h84);
        end
        $display("pin flag test done");
    endtask

    task automatic t_readonly();
        bus(1'b1, 8'h1C, 32'hFF);
        st(8'hFF);
        bus(1'b0, 8'hFC, 32'h0);
        check(rd, 32'h0);
        bus(1'b0, 8'h48, 32'h0);
        check(rd, {24'h0, model()});
        $display("read-only test done");
    endtask

    task automatic t_irq();
        bus(1'b1, 8'h44, 32'h04);
        bus(1'b1, 8'h40, 32'hFF);
        idle(2);
        check({31'h0, irq}, 32'h0);
        field_detect <= 1'b1;
        idle(12);
        check({31'h0, irq}, 32'h1);
        bus(1'b0, 8'h40, 32'h0);
        check(rd & 32'h04, 32'h04);
        bus(1'b1, 8'h40, 32'h04);
        idle(2);
        check({31'h0, irq}, 32'h0);
        comm_irq_source <= 7'h01;
        comm_irq_enable_register <= 7'h01;
        idle(6);
        check({31'h0, irq}, 32'h0);
        bus(1'b1, 8'h44, 32'h10);
        idle(2);
        check({31'h0, irq}, 32'h1);
        bus(1'b1, 8'h40, 32'h10);
        idle(2);
        check({31'h0, irq}, 32'h0);
        $display("interrupt test done");
    endtask

    ////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        {rstn, avs_read, avs_write, avs_address, avs_writedata, rx_freq_in_band, field_detect} = '0;
        {checksum_result, checksum_busy, checksum_finish, compute_checksum_cmd, link_active} = '0;
        {comm_irq_source, comm_irq_enable_register, misc_irq_source, misc_irq_enable_register} = '0;
        {timer_running, timer_gated_mode, timer_enable_bits, fifo_fill_count, fifo_threshold} = '0;
        avs_byteenable = 4'hF;
        done_model = 1'b0;
        mismatches = 0;
        checks_done = 0;
        repeat (8) @(posedge core_clk);
        rstn <= 1'b1;
        t_fifo();
        t_attention();
        t_timer();
        t_checksum();
        t_pins();
        t_readonly();
        t_irq();
        results();
    end
endmodule

bind summary_status summary_status_checker #(.ADDR_W(ADDR_W), .CHECKSUM_W(CHECKSUM_W), .COMM_IRQ_W(COMM_IRQ_W),
    .MISC_IRQ_W(MISC_IRQ_W), .COUNT_W(COUNT_W), .THRESH_W(THRESH_W)) summary_status_checker_inst (.core_clk,
    .rstn, .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .rx_freq_in_band, .field_detect,
    .checksum_result, .checksum_busy, .checksum_finish, .compute_checksum_cmd, .link_active, .comm_irq_source,
    .comm_irq_enable_register, .misc_irq_source, .misc_irq_enable_register, .timer_running, .timer_gated_mode,
    .timer_enable_bits, .fifo_fill_count, .fifo_threshold);
